// File: cbse_pkg.sv
// Shared constants, opcodes and carriers for the branch, bit and shift execution block
package cbse_pkg;

	localparam int ADDR_W     = 12;
	localparam int GPR_IDX_W  = 5;
	localparam int IO_IDX_W   = 6;
	localparam int DMEM_IDX_W = 8;

	// Register offsets on the APB side
	localparam logic [11:0] OFF_INSTR = 12'h000;
	localparam logic [11:0] OFF_STAT  = 12'h004;
	localparam logic [11:0] OFF_FLAGS = 12'h008;
	localparam logic [11:0] OFF_PC    = 12'h00C;
	localparam logic [11:0] BASE_GPR  = 12'h100;
	localparam logic [11:0] BASE_IO   = 12'h200;
	localparam logic [11:0] BASE_DMEM = 12'h400;

	// Status word layout
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_CYC_LSB  = 8;

	// Flag positions inside the status register
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_V = 3;
	localparam int FLG_S = 4;
	localparam int FLG_H = 5;
	localparam int FLG_T = 6;
	localparam int FLG_I = 7;

	// Reset values, pointer pair base and cycle count codes
	localparam logic [7:0]  FLAGS_RST  = 8'h00;
	localparam logic [15:0] PC_RST     = 16'h0000;
	localparam logic [4:0]  PTR_BASE   = 5'h1A;
	localparam logic [1:0]  CYC_ONE    = 2'h1;
	localparam logic [1:0]  CYC_TWO    = 2'h2;

	typedef enum logic [5:0] {
		OP_NOP,
		OP_BRANCH_SIGNED_LESS,
		OP_BRANCH_HALF_CARRY_HIGH,
		OP_BRANCH_HALF_CARRY_LOW,
		OP_BRANCH_TRANSFER_HIGH,
		OP_BRANCH_TRANSFER_LOW,
		OP_BRANCH_OVERFLOW_HIGH,
		OP_BRANCH_OVERFLOW_LOW,
		OP_BRANCH_IRQ_ON,
		OP_BRANCH_IRQ_OFF,
		OP_IO_BIT_SET,
		OP_IO_BIT_CLEAR,
		OP_LOGICAL_LEFT_SHIFT,
		OP_LOGICAL_RIGHT_SHIFT,
		OP_ROTATE_LEFT_VIA_CARRY,
		OP_ARITHMETIC_RIGHT_SHIFT,
		OP_STATUS_BIT_FORCE_ONE,
		OP_STATUS_BIT_FORCE_ZERO,
		OP_BIT_TO_TRANSFER_FLAG,
		OP_TRANSFER_FLAG_TO_BIT,
		OP_GLOBAL_IRQ_ON,
		OP_GLOBAL_IRQ_OFF,
		OP_COPY_BYTE_BETWEEN_REGS,
		OP_INDIRECT_LOAD_POST_INC,
		OP_INDIRECT_LOAD_PRE_DEC
	} cbse_op_e;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EX1,
		ST_EX2
	} cbse_state_e;

	// Instruction word as written to the instruction register
	typedef struct packed {
		logic [1:0] rsv3;
		logic [1:0] ptr;
		logic       rsv2;
		logic [2:0] bitsel;
		logic       rsv1;
		logic [6:0] opnd;
		logic [2:0] rsv0;
		logic [4:0] dst;
		logic [1:0] rsv_op;
		cbse_op_e   op;
	} cbse_instr_s;

endpackage : cbse_pkg

// File: cbse_exec.sv
// Execution unit for branches, bit operations, shifts, flag ops, moves and indirect loads
// How it works
// RQ1 - Signed-less branch jumps to pc plus offset plus one when N xor V set
// RQ2 - Half-carry branches jump on H one or zero, flags untouched
// RQ3 - Transfer-flag branches jump on T one or zero, flags untouched
// RQ4 - Overflow branches jump on V one or zero, flags untouched
// RQ5 - Interrupt-state branches jump on I one or zero, flags untouched
// RQ6 - I/O bit set or clear forces one addressed bit, no flags, two cycles
// RQ7 - Logical shifts move one place, zero fill, update Z C N V, one cycle
// RQ8 - Rotate left puts old carry in bit 0, bit 7 to carry
// RQ9 - Arithmetic right shift keeps bit 7, updates Z C N V, one cycle
// RQ10 - Bit store copies selected register bit into T only
// RQ11 - Bit load writes T into selected register bit, flags untouched
// RQ12 - Global interrupt on and off set or clear I only, one cycle
// RQ13 - Single status-bit set or clear writes only that flag, one cycle
// RQ14 - Register copy moves source into destination, no flags, one cycle
// RQ15 - Post-increment load reads at pointer then bumps pointer, two cycles
// RQ16 - Pre-decrement load drops pointer then reads new address, two cycles
// RQ17 - Untaken branch costs one cycle, taken branch two cycles
module cbse_exec
	import cbse_pkg::*;
(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB request
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	// APB answer
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr
);

	// Architectural storage
	logic [7:0]  gpr  [2**GPR_IDX_W];
	logic [7:0]  io   [2**IO_IDX_W];
	logic [7:0]  dmem [2**DMEM_IDX_W];

	cbse_instr_s cur;
	cbse_state_e st;
	cbse_state_e next_st;
	logic [7:0]  status_register;
	logic [15:0] pc;
	logic [1:0]  last_cycles;

	// Bus decode
	wire logic                  apb_done = psel & penable & pready;
	wire logic                  busy     = (st != ST_IDLE);
	wire logic                  aligned  = (paddr[1:0] == 2'h0);
	wire logic                  hit_instr = (paddr == OFF_INSTR);
	wire logic                  hit_stat  = (paddr == OFF_STAT);
	wire logic                  hit_flags = (paddr == OFF_FLAGS);
	wire logic                  hit_pc    = (paddr == OFF_PC);
	wire logic                  hit_gpr   = aligned &
		(paddr[ADDR_W-1:GPR_IDX_W+2] == BASE_GPR[ADDR_W-1:GPR_IDX_W+2]);
	wire logic                  hit_io    = aligned &
		(paddr[ADDR_W-1:IO_IDX_W+2] == BASE_IO[ADDR_W-1:IO_IDX_W+2]);
	wire logic                  hit_dmem  = aligned &
		(paddr[ADDR_W-1:DMEM_IDX_W+2] == BASE_DMEM[ADDR_W-1:DMEM_IDX_W+2]);
	wire logic                  mapped = hit_instr | hit_stat | hit_flags | hit_pc |
		hit_gpr | hit_io | hit_dmem;
	// Writes during execution are refused so software never races the unit
	wire logic                  bad    = ~mapped | (pwrite & (busy | hit_stat));
	wire logic                  wr_en  = apb_done & pwrite & ~pslverr;
	wire logic [GPR_IDX_W-1:0]  a_gidx = paddr[GPR_IDX_W+1:2];
	wire logic [IO_IDX_W-1:0]   a_iidx = paddr[IO_IDX_W+1:2];
	wire logic [DMEM_IDX_W-1:0] a_didx = paddr[DMEM_IDX_W+1:2];

	wire logic [31:0] stat_word = {22'h00_0000, last_cycles, 7'h00, busy};
	wire logic [31:0] rd_data =
		hit_instr ? cur :
		hit_stat  ? stat_word :
		hit_flags ? {24'h00_0000, status_register} :
		hit_pc    ? {16'h0000, pc} :
		hit_gpr   ? {24'h00_0000, gpr[a_gidx]} :
		hit_io    ? {24'h00_0000, io[a_iidx]} :
		hit_dmem  ? {24'h00_0000, dmem[a_didx]} : 32'h0000_0000;

	// Operand fetch
	wire logic            ex1     = (st == ST_EX1);
	wire logic            ex2     = (st == ST_EX2);
	wire cbse_op_e        op      = cur.op;
	wire logic [7:0]      rd_val  = gpr[cur.dst];
	wire logic [7:0]      rr_val  = gpr[cur.opnd[GPR_IDX_W-1:0]];
	wire logic [4:0]      ptr_lo  = PTR_BASE + {2'h0, cur.ptr, 1'b0};
	wire logic [4:0]      ptr_hi  = ptr_lo + 5'h01;
	wire logic [15:0]     ptr     = {gpr[ptr_hi], gpr[ptr_lo]};
	wire logic [7:0]      mem_at  = dmem[ptr[DMEM_IDX_W-1:0]];
	wire logic            f_c     = status_register[FLG_C];
	wire logic            f_n     = status_register[FLG_N];
	wire logic            f_v     = status_register[FLG_V];
	wire logic            f_h     = status_register[FLG_H];
	wire logic            f_t     = status_register[FLG_T];
	wire logic            f_i     = status_register[FLG_I];

	// Branch decode
	wire logic is_branch = (op >= OP_BRANCH_SIGNED_LESS) && (op <= OP_BRANCH_IRQ_OFF);
	wire logic br_cond =
		(op == OP_BRANCH_SIGNED_LESS)     ? (f_n ^ f_v) :      // [RQ1]
		(op == OP_BRANCH_HALF_CARRY_HIGH) ? f_h :              // [RQ2]
		(op == OP_BRANCH_HALF_CARRY_LOW)  ? ~f_h :             // [RQ2]
		(op == OP_BRANCH_TRANSFER_HIGH)   ? f_t :              // [RQ3]
		(op == OP_BRANCH_TRANSFER_LOW)    ? ~f_t :             // [RQ3]
		(op == OP_BRANCH_OVERFLOW_HIGH)   ? f_v :              // [RQ4]
		(op == OP_BRANCH_OVERFLOW_LOW)    ? ~f_v :             // [RQ4]
		(op == OP_BRANCH_IRQ_ON)          ? f_i :              // [RQ5]
		(op == OP_BRANCH_IRQ_OFF)         ? ~f_i : 1'b0;       // [RQ5]
	wire logic        br_taken = is_branch & br_cond;
	wire logic [15:0] br_tgt   = pc + {{9{cur.opnd[6]}}, cur.opnd} + 16'h0001;

	wire logic is_io    = (op == OP_IO_BIT_SET) || (op == OP_IO_BIT_CLEAR);
	wire logic is_post  = (op == OP_INDIRECT_LOAD_POST_INC);
	wire logic is_pre   = (op == OP_INDIRECT_LOAD_PRE_DEC);
	wire logic two_cyc  = br_taken | is_io | is_post | is_pre;  // [RQ6] [RQ17]
	wire logic is_shift = (op >= OP_LOGICAL_LEFT_SHIFT) && (op <= OP_ARITHMETIC_RIGHT_SHIFT);

	// Shifter
	wire logic [7:0] sh_res =
		(op == OP_LOGICAL_LEFT_SHIFT)    ? {rd_val[6:0], 1'b0} :     // [RQ7]
		(op == OP_LOGICAL_RIGHT_SHIFT)   ? {1'b0, rd_val[7:1]} :     // [RQ7]
		(op == OP_ROTATE_LEFT_VIA_CARRY) ? {rd_val[6:0], f_c} :      // [RQ8]
		{rd_val[7], rd_val[7:1]};                                     // [RQ9]
	wire logic sh_c = ((op == OP_LOGICAL_LEFT_SHIFT) || (op == OP_ROTATE_LEFT_VIA_CARRY)) ?
		rd_val[7] : rd_val[0];
	wire logic sh_n = sh_res[7];
	wire logic sh_z = (sh_res == 8'h00);

	// Single data write port for the destination register
	wire logic       gpr_we = (ex1 & (is_shift | is_post |
		(op == OP_TRANSFER_FLAG_TO_BIT) | (op == OP_COPY_BYTE_BETWEEN_REGS))) | (ex2 & is_pre);
	wire logic [7:0] tfb_val = (rd_val & ~(8'h01 << cur.bitsel)) |
		({7'h00, f_t} << cur.bitsel);                                 // [RQ11]
	wire logic [7:0] gpr_wd =
		is_shift                           ? sh_res :                 // [RQ7]
		(op == OP_TRANSFER_FLAG_TO_BIT)    ? tfb_val :                // [RQ11]
		(op == OP_COPY_BYTE_BETWEEN_REGS)  ? rr_val : mem_at;         // [RQ14] [RQ15] [RQ16]

	// Pointer pair port: decrement before the read, increment after it
	wire logic        ptr_we = (ex1 & is_pre) | (ex2 & is_post);     // [RQ15] [RQ16]
	wire logic [15:0] ptr_wd = is_pre ? (ptr - 16'h0001) : (ptr + 16'h0001);

	// Sequencer
	always_comb begin
		next_st = st;
		case (st)
			ST_IDLE: begin
				if (wr_en & hit_instr) begin
					next_st = ST_EX1;
				end
			end
			ST_EX1: begin
				next_st = two_cyc ? ST_EX2 : ST_IDLE;                 // [RQ17]
			end
			default: begin
				next_st = ST_IDLE;
			end
		endcase
	end

	// APB answer: one wait cycle, then pready for a single cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			if (psel & penable & ~pready) begin
				prdata  <= rd_data;
				pslverr <= bad;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st          <= ST_IDLE;
			cur         <= '0;
			pc          <= PC_RST;
			last_cycles <= 2'h0;
		end else begin
			st <= next_st;
			if (wr_en & hit_instr) begin
				cur <= cbse_instr_s'(pwdata);
			end else if (wr_en & hit_pc) begin
				pc <= pwdata[15:0];
			end
			if (ex1 & ~br_taken) begin
				pc <= pc + 16'h0001;                                  // [RQ17]
			end
			if (ex2 & is_branch) begin
				pc <= br_tgt;                                         // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5]
			end
			if (ex1 & ~two_cyc) begin
				last_cycles <= CYC_ONE;
			end else if (ex2) begin
				last_cycles <= CYC_TWO;
			end
		end
	end

	// Flags: only the ops below touch them, branches and loads never do
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_register <= FLAGS_RST;
		end else if (wr_en & hit_flags) begin
			status_register <= pwdata[7:0];
		end else if (ex1) begin
			if (is_shift) begin
				status_register[FLG_C] <= sh_c;                       // [RQ7] [RQ8] [RQ9]
				status_register[FLG_Z] <= sh_z;
				status_register[FLG_N] <= sh_n;
				status_register[FLG_V] <= sh_n ^ sh_c;
			end else if (op == OP_STATUS_BIT_FORCE_ONE) begin
				status_register[cur.bitsel] <= 1'b1;                  // [RQ13]
			end else if (op == OP_STATUS_BIT_FORCE_ZERO) begin
				status_register[cur.bitsel] <= 1'b0;                  // [RQ13]
			end else if (op == OP_BIT_TO_TRANSFER_FLAG) begin
				status_register[FLG_T] <= rd_val[cur.bitsel];         // [RQ10]
			end else if (op == OP_GLOBAL_IRQ_ON) begin
				status_register[FLG_I] <= 1'b1;                       // [RQ12]
			end else if (op == OP_GLOBAL_IRQ_OFF) begin
				status_register[FLG_I] <= 1'b0;                       // [RQ12]
			end
		end
	end

	// Storage arrays carry no reset, like any register file
	always_ff @(posedge pclk) begin
		if (wr_en & hit_gpr) begin
			gpr[a_gidx] <= pwdata[7:0];
		end
		if (wr_en & hit_io) begin
			io[a_iidx] <= pwdata[7:0];
		end
		if (wr_en & hit_dmem) begin
			dmem[a_didx] <= pwdata[7:0];
		end
		if (gpr_we) begin
			gpr[cur.dst] <= gpr_wd;
		end
		if (ptr_we) begin
			gpr[ptr_lo] <= ptr_wd[7:0];
			gpr[ptr_hi] <= ptr_wd[15:8];
		end
		if (ex2 & is_io) begin
			io[cur.opnd[IO_IDX_W-1:0]][cur.bitsel] <= (op == OP_IO_BIT_SET); // [RQ6]
		end
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	wire logic       dst_clash = (cur.dst == ptr_lo) || (cur.dst == ptr_hi);
	wire logic [7:0] mem_below = dmem[ptr[DMEM_IDX_W-1:0] - 8'h01];

	sequence s_two_step;
		ex2 ##1 (st == ST_IDLE);
	endsequence

	property p_signed_less;
		(ex1 && op == OP_BRANCH_SIGNED_LESS && (f_n ^ f_v)) |=> s_two_step and
			(##1 pc == $past(br_tgt, 2));
	endproperty
	a_signed_less: assert property (p_signed_less) else $error("signed branch target wrong"); // [RQ1]

	property p_half_carry;
		(ex1 && ((op == OP_BRANCH_HALF_CARRY_HIGH && f_h) ||
			(op == OP_BRANCH_HALF_CARRY_LOW && !f_h))) |=> ex2 ##1
			(pc == $past(br_tgt, 2) && status_register == $past(status_register, 2));
	endproperty
	a_half_carry: assert property (p_half_carry) else $error("half-carry branch wrong"); // [RQ2]

	property p_flag_branch;
		(ex1 && br_taken && op >= OP_BRANCH_TRANSFER_HIGH) |=> ex2 ##1
			(pc == $past(br_tgt, 2) && status_register == $past(status_register, 2));
	endproperty
	a_flag_branch: assert property (p_flag_branch) else $error("flag branch wrong"); // [RQ3] [RQ4] [RQ5]

	property p_fall_through;
		(ex1 && is_branch && !br_cond) |=> (st == ST_IDLE) && (pc == $past(pc) + 16'h0001);
	endproperty
	a_fall_through: assert property (p_fall_through) else $error("untaken branch wrong"); // [RQ17]

	property p_io_bit;
		(ex1 && is_io) |=> s_two_step and (##1 status_register == $past(status_register, 2)) and
			(##1 io[$past(cur.opnd[IO_IDX_W-1:0], 2)][$past(cur.bitsel, 2)] ==
			($past(op, 2) == OP_IO_BIT_SET));
	endproperty
	a_io_bit: assert property (p_io_bit) else $error("io bit op wrong"); // [RQ6]

	property p_shift_left;
		(ex1 && op == OP_LOGICAL_LEFT_SHIFT) |=> (st == ST_IDLE) && f_c == $past(rd_val[7]) &&
			gpr[$past(cur.dst)] == {$past(rd_val[6:0]), 1'b0};
	endproperty
	a_shift_left: assert property (p_shift_left) else $error("left shift wrong"); // [RQ7]

	property p_rotate;
		(ex1 && op == OP_ROTATE_LEFT_VIA_CARRY) |=> f_c == $past(rd_val[7]) &&
			gpr[$past(cur.dst)] == {$past(rd_val[6:0]), $past(f_c)};
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotate wrong"); // [RQ8]

	property p_arith_right;
		(ex1 && op == OP_ARITHMETIC_RIGHT_SHIFT) |=> f_c == $past(rd_val[0]) &&
			gpr[$past(cur.dst)] == {$past(rd_val[7]), $past(rd_val[7:1])};
	endproperty
	a_arith_right: assert property (p_arith_right) else $error("arith shift wrong"); // [RQ9]

	property p_bit_store;
		(ex1 && op == OP_BIT_TO_TRANSFER_FLAG) |=> f_t == $past(rd_val[cur.bitsel]);
	endproperty
	a_bit_store: assert property (p_bit_store) else $error("bit store wrong"); // [RQ10]

	property p_bit_load;
		(ex1 && op == OP_TRANSFER_FLAG_TO_BIT) |=> status_register == $past(status_register) &&
			gpr[$past(cur.dst)][$past(cur.bitsel)] == $past(f_t);
	endproperty
	a_bit_load: assert property (p_bit_load) else $error("bit load wrong"); // [RQ11]

	property p_irq_on;
		(ex1 && op == OP_GLOBAL_IRQ_ON) |=> f_i && status_register[6:0] == $past(status_register[6:0]);
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq enable wrong"); // [RQ12]

	property p_force_zero;
		(ex1 && op == OP_STATUS_BIT_FORCE_ZERO) |=> !status_register[$past(cur.bitsel)];
	endproperty
	a_force_zero: assert property (p_force_zero) else $error("flag clear wrong"); // [RQ13]

	property p_force_one;
		(ex1 && op == OP_STATUS_BIT_FORCE_ONE) |=>
			status_register == ($past(status_register) | (8'h01 << $past(cur.bitsel)));
	endproperty
	a_force_one: assert property (p_force_one) else $error("flag set wrong"); // [RQ13]

	property p_copy;
		(ex1 && op == OP_COPY_BYTE_BETWEEN_REGS) |=> gpr[$past(cur.dst)] == $past(rr_val) &&
			status_register == $past(status_register);
	endproperty
	a_copy: assert property (p_copy) else $error("register copy wrong"); // [RQ14]

	property p_post_inc;
		(ex1 && is_post && !dst_clash) |=> ex2 ##1
			(gpr[$past(cur.dst, 2)] == $past(mem_at, 2) && ptr == $past(ptr, 2) + 16'h0001);
	endproperty
	a_post_inc: assert property (p_post_inc) else $error("post-inc load wrong"); // [RQ15]

	property p_pre_dec;
		(ex1 && is_pre && !dst_clash) |=> ex2 ##1
			(gpr[$past(cur.dst, 2)] == $past(mem_below, 2) && ptr == $past(ptr, 2) - 16'h0001);
	endproperty
	a_pre_dec: assert property (p_pre_dec) else $error("pre-dec load wrong"); // [RQ16]

endmodule : cbse_exec

// File: cbse_exec_tb_top.sv
// Self-checking bench for the branch, bit and shift execution block
module cbse_exec_tb_top
	import cbse_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [31:0]       seed;
	logic [31:0]       rd;
	logic              err;
	int                mismatches;
	int                num_checks;

	cbse_exec uut (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr)
	);

	always #2.5 pclk = ~pclk;

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd

	function automatic logic [11:0] ga(input logic [11:0] base, input logic [7:0] i);
		return base + {2'b00, i, 2'b00};
	endfunction : ga

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic complete_run();
		if (mismatches == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n >= 20) chk("pready", 32'h0000_0001, 32'h0000_0000);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rc(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rd);
	endtask : rc

	// Issues one instruction, waits for idle, checks cycle count and pc step
	task automatic run(input cbse_op_e op, input logic [4:0] dst, input logic [6:0] opn,
			input logic [2:0] bs, input logic [1:0] ptr, input logic [15:0] dpc,
			input logic [1:0] cyc);
		logic [15:0] pc0;
		cbse_instr_s ins;
		int          n;
		apb(1'b0, OFF_PC, 32'h0000_0000);
		pc0 = rd[15:0];
		ins = '0;
		ins.op = op;
		ins.dst = dst;
		ins.opnd = opn;
		ins.bitsel = bs;
		ins.ptr = ptr;
		apb(1'b1, OFF_INSTR, ins);
		n = 0;
		do begin
			apb(1'b0, OFF_STAT, 32'h0000_0000);
			n++;
		end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 10);
		chk("cycles", {30'h0, cyc}, {30'h0, rd[STAT_CYC_LSB+:2]});
		rc("pc", OFF_PC, {16'h0000, pc0 + dpc});
	endtask : run

	initial begin
		logic [31:0] r;
		logic [7:0]  f, v, ev, ef, sv, dv;
		logic [6:0]  k;
		logic [4:0]  d, s, lo;
		logic [5:0]  x;
		logic [2:0]  b;
		logic [11:0] a;
		logic [15:0] pv, ea;
		logic [1:0]  cy;
		logic        t, c, pre;
		cbse_op_e    op;
		int          o;
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		mismatches = 0;
		num_checks = 0;
		seed = 32'h0000_c93c;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rc("flags_rst", OFF_FLAGS, 32'h0000_0000);
		rc("pc_rst", OFF_PC, 32'h0000_0000);
		rc("unmapped", 12'h010, 32'h0000_0000);
		chk("unmapped_err", 32'h0000_0001, {31'h0, err});
		rc("instr_rst", OFF_INSTR, 32'h0000_0000);
		rc("unaligned", 12'h106, 32'h0000_0000);
		chk("unaligned_err", 32'h0000_0001, {31'h0, err});
		apb(1'b1, OFF_STAT, 32'h0000_0001);
		chk("stat_wr_err", 32'h0000_0001, {31'h0, err});
		apb(1'b1, OFF_FLAGS, 32'h0000_0000);
		chk("flags_wr_err", 32'h0000_0000, {31'h0, err});
		run(OP_NOP, 5'h00, 7'h00, 3'h0, 2'h0, 16'h1, CYC_ONE);
		// Branches, with extreme offsets first
		for (int i = 0; i < 72; i++) begin
			o = 1 + i % 9;
			r = rnd();
			f = r[7:0];
			k = (i < 9) ? 7'h40 : (i < 18) ? 7'h3f : r[14:8];
			apb(1'b1, OFF_FLAGS, {24'h0, f});
			apb(1'b1, OFF_PC, {16'h0, r[31:16]});
			b = 3'((o < 4) ? FLG_H : (o < 6) ? FLG_T : (o < 8) ? FLG_V : FLG_I);
			t = (o == 1) ? f[FLG_N] ^ f[FLG_V] : f[b] ^ o[0];
			run(cbse_op_e'(o), 5'h00, k, 3'h0, 2'h0, t ? {{9{k[6]}}, k} + 16'h1 : 16'h1,
				t ? CYC_TWO : CYC_ONE);
			rc("branch_flags", OFF_FLAGS, {24'h0, f});
		end
		// Shifts and rotate, edge values first
		for (int i = 0; i < 40; i++) begin
			r = rnd();
			op = cbse_op_e'(12 + i % 4);
			v = (i < 4) ? 8'h80 : (i < 8) ? 8'h01 : r[7:0];
			f = r[15:8];
			d = r[20:16];
			apb(1'b1, ga(BASE_GPR, {3'h0, d}), {24'h0, v});
			apb(1'b1, OFF_FLAGS, {24'h0, f});
			case (i % 4)
				0: {c, ev} = {v, 1'b0};
				1: {ev, c} = {1'b0, v};
				2: {c, ev} = {v, f[FLG_C]};
				default: {ev, c} = {v[7], v};
			endcase
			ef = f;
			ef[FLG_C] = c;
			ef[FLG_Z] = (ev == 8'h00);
			ef[FLG_N] = ev[7];
			ef[FLG_V] = ev[7] ^ c;
			run(op, d, 7'h00, 3'h0, 2'h0, 16'h1, CYC_ONE);
			rc("shift_res", ga(BASE_GPR, {3'h0, d}), {24'h0, ev});
			rc("shift_flags", OFF_FLAGS, {24'h0, ef});
		end
		// Every status bit forced both ways, then global interrupt on and off
		for (int i = 0; i < 18; i++) begin
			r = rnd();
			f = r[7:0];
			ef = f;
			ef[(i < 16) ? i % 8 : FLG_I] = (i < 8 || i == 16);
			op = (i < 8) ? OP_STATUS_BIT_FORCE_ONE : (i < 16) ? OP_STATUS_BIT_FORCE_ZERO :
				(i == 16) ? OP_GLOBAL_IRQ_ON : OP_GLOBAL_IRQ_OFF;
			apb(1'b1, OFF_FLAGS, {24'h0, f});
			run(op, 5'h00, 7'h00, 3'(i % 8), 2'h0, 16'h1, CYC_ONE);
			rc("flag_op", OFF_FLAGS, {24'h0, ef});
		end
		// I/O bit ops, transfer-flag moves and register copy
		for (int i = 0; i < 40; i++) begin
			r = rnd();
			v = r[7:0];
			f = r[15:8];
			b = r[18:16];
			d = r[23:19];
			s = r[28:24];
			x = r[29:24];
			sv = ~v ^ r[31:24];
			ef = f;
			ev = v;
			cy = CYC_ONE;
			a = ga(BASE_GPR, {3'h0, d});
			case (i % 5)
				0: begin
					op = OP_IO_BIT_SET;
					a = ga(BASE_IO, {2'h0, x});
					ev[b] = 1'b1;
					cy = CYC_TWO;
				end
				1: begin
					op = OP_IO_BIT_CLEAR;
					a = ga(BASE_IO, {2'h0, x});
					ev[b] = 1'b0;
					cy = CYC_TWO;
				end
				2: begin
					op = OP_BIT_TO_TRANSFER_FLAG;
					ef[FLG_T] = v[b];
				end
				3: begin
					op = OP_TRANSFER_FLAG_TO_BIT;
					ev[b] = f[FLG_T];
				end
				default: begin
					op = OP_COPY_BYTE_BETWEEN_REGS;
					ev = sv;
				end
			endcase
			apb(1'b1, OFF_FLAGS, {24'h0, f});
			apb(1'b1, a, {24'h0, v});
			if (i % 5 == 4) apb(1'b1, ga(BASE_GPR, {3'h0, s}), {24'h0, sv});
			run(op, d, (i % 5 < 2) ? {1'b0, x} : {2'b0, s}, b, 2'h0, 16'h1,
				cy);
			rc("bit_res", a, {24'h0, ev});
			rc("bit_flags", OFF_FLAGS, {24'h0, ef});
		end
		// Indirect loads on pointer pairs 0 to 2, byte carry and borrow first
		for (int i = 0; i < 12; i++) begin
			r = rnd();
			pre = ((i / 3) % 2) == 1;
			pv = (i < 3) ? 16'h00ff : (i < 6) ? 16'h0100 : r[15:0];
			ea = pre ? pv - 16'h1 : pv;
			dv = r[23:16];
			f = r[31:24];
			lo = PTR_BASE + {2'(i % 3), 1'b0};
			apb(1'b1, ga(BASE_DMEM, ea[7:0]), {24'h0, dv});
			apb(1'b1, ga(BASE_GPR, {3'h0, lo}), {24'h0, pv[7:0]});
			apb(1'b1, ga(BASE_GPR, {3'h0, lo + 5'h1}), {24'h0, pv[15:8]});
			apb(1'b1, OFF_FLAGS, {24'h0, f});
			pv = pre ? pv - 16'h1 : pv + 16'h1;
			run(pre ? OP_INDIRECT_LOAD_PRE_DEC : OP_INDIRECT_LOAD_POST_INC, 5'(i), 7'h00,
				3'h0, 2'(i % 3), 16'h1, CYC_TWO);
			rc("load_data", ga(BASE_GPR, 8'(i)), {24'h0, dv});
			rc("ptr_lo", ga(BASE_GPR, {3'h0, lo}), {24'h0, pv[7:0]});
			rc("ptr_hi", ga(BASE_GPR, {3'h0, lo + 5'h1}), {24'h0, pv[15:8]});
			rc("load_flags", OFF_FLAGS, {24'h0, f});
		end
		complete_run();
	end

	// Whole run needs far fewer cycles than this
	initial begin
		repeat (60000) @(posedge pclk);
		mismatches++;
		complete_run();
	end

endmodule : cbse_exec_tb_top
